// [verilog/lsl_top.sv]
// lsl_top: link status reporting and master loopback data path, plus its fifo
// assumes: training logic and lane logic run on CLK_I; software uses the
// plain register port with read data one cycle after the read strobe
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// fifo with valid/ready on both sides
// ----------------------------------------------------------------------
module lsl_fifo #(
    parameter int WIDTH = 72,
    parameter int DEPTH = 8
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;

    // handshakes come straight from the fill level
    assign in_ready_o = (count_reg != FULL_COUNT);
    assign out_valid_o = (count_reg != '0);
    assign out_data_o = mem[rd_ptr_reg];
    assign count_o = count_reg;

    // storage array, written only on an accepted push
    always_ff @(posedge CLK_I) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

    // pointers and level
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    property p_fifo_bound;
        @(posedge CLK_I) disable iff (RST_I) count_reg <= FULL_COUNT;
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("fifo level above depth");
endmodule

// ----------------------------------------------------------------------
// top: status outputs, registers and loopback paths
// ----------------------------------------------------------------------
module lsl_top #(
    parameter lsl_pkg::lsl_variant_e VARIANT = lsl_pkg::VAR_G1_X4,
    parameter bit LBK_OPTION = 1'b1,
    parameter int FIFO_DEPTH = lsl_pkg::FIFO_DEPTH
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    // register port
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [31:0] REG_RDATA_O,
    // training machine side
    input wire logic [3:0] LTSSM_STATE_I,
    input wire logic POL_CMPL_SUB_I,
    input wire logic [3:0] LANE_IN_CFG_I,
    // status outputs
    output logic [3:0] CFG_LANES_O,
    output logic [2:0] LINK_WIDTH_O,
    output logic POL_COMPLIANCE_O,
    // user transmit loopback
    output logic TX_LBK_RDY_O,
    input wire logic [7:0] TX_LBK_KCNTL_I,
    input wire logic [63:0] TX_LBK_DATA_I,
    // user receive loopback
    output logic [7:0] RX_LBK_KCNTL_O,
    output logic [63:0] RX_LBK_DATA_O,
    // lane side
    output logic [63:0] LANE_TX_DATA_O,
    output logic [7:0] LANE_TX_KCNTL_O,
    output logic LANE_TX_VALID_O,
    input wire logic LANE_TX_READY_I,
    input wire logic [63:0] LANE_RX_DATA_I,
    input wire logic [7:0] LANE_RX_KCNTL_I,
    input wire logic LANE_RX_VALID_I
);
    localparam bit NARROW = (VARIANT == lsl_pkg::VAR_G1_X1);
    localparam int LBK_W = NARROW ? lsl_pkg::LBK_W_NARROW : lsl_pkg::LBK_W_WIDE;
    localparam int LANES_USED = LBK_W / lsl_pkg::LANE_W;
    localparam int WORD_W = $bits(lsl_pkg::lsl_lbk_word_s);
    localparam int CW = $clog2(FIFO_DEPTH) + 1;

    logic [31:0] ctrl_reg;
    logic [31:0] rdata_reg;
    logic [3:0] cfg_lanes_reg;
    logic [3:0] cfg_lanes_next;
    logic [2:0] width_reg;
    logic [2:0] width_next;
    logic cmpl_reg;
    lsl_pkg::lsl_lbk_word_s tx_out_reg;
    logic tx_valid_reg;
    lsl_pkg::lsl_lbk_word_s rx_out_reg;
    lsl_pkg::lsl_lbk_word_s rx_mask;
    lsl_pkg::lsl_lbk_word_s tx_in_word;
    lsl_pkg::lsl_lbk_word_s fifo_out_word;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [CW-1:0] fifo_count;

    // ------------------------------------------------------------------
    // lane participation and width
    // ------------------------------------------------------------------
    wire in_config = (LTSSM_STATE_I == lsl_pkg::LTSSM_CONFIG);
    wire [2:0] lane_sum = 3'(LANE_IN_CFG_I[0]) + 3'(LANE_IN_CFG_I[1])
        + 3'(LANE_IN_CFG_I[2]) + 3'(LANE_IN_CFG_I[3]);

    // reversed bit order; the 5G core fills the two low bits only
    always_comb begin
        cfg_lanes_next = cfg_lanes_reg;
        if (in_config) begin
            if (VARIANT == lsl_pkg::VAR_G2_X2) begin
                cfg_lanes_next = {2'h0, LANE_IN_CFG_I[0], LANE_IN_CFG_I[1]};
            end else if (NARROW) begin
                cfg_lanes_next = {LANE_IN_CFG_I[0], 3'h0};
            end else begin
                cfg_lanes_next = {LANE_IN_CFG_I[0], LANE_IN_CFG_I[1],
                    LANE_IN_CFG_I[2], LANE_IN_CFG_I[3]};
            end
        end
    end

    // width code from the count of lanes that negotiate
    always_comb begin
        width_next = width_reg;
        if (in_config) begin
            unique case (lane_sum)
                3'h1: width_next = lsl_pkg::WIDTH_X1;
                3'h2, 3'h3: width_next = lsl_pkg::WIDTH_X2;
                3'h4: width_next = (VARIANT == lsl_pkg::VAR_G2_X2) ?
                    lsl_pkg::WIDTH_X2 : lsl_pkg::WIDTH_X4;
                default: width_next = lsl_pkg::WIDTH_NONE;
            endcase
            if (NARROW) begin
                width_next = lsl_pkg::WIDTH_NONE;
            end
        end
    end

    // status flops
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            cfg_lanes_reg <= 4'h0;
            width_reg <= lsl_pkg::WIDTH_NONE;
            cmpl_reg <= 1'b0;
        end else begin
            cfg_lanes_reg <= cfg_lanes_next;
            width_reg <= width_next;
            cmpl_reg <= (LTSSM_STATE_I == lsl_pkg::LTSSM_POLLING) && POL_CMPL_SUB_I;
        end
    end

    assign CFG_LANES_O = cfg_lanes_reg;
    assign LINK_WIDTH_O = width_reg;
    assign POL_COMPLIANCE_O = cmpl_reg;

    // ------------------------------------------------------------------
    // register port
    // ------------------------------------------------------------------
    wire sel_ctrl = (REG_ADDR_I == lsl_pkg::REG_CTRL);
    wire sel_status = (REG_ADDR_I == lsl_pkg::REG_STATUS);
    wire sel_fifo = (REG_ADDR_I == lsl_pkg::REG_FIFO);
    wire lbk_on = LBK_OPTION && ctrl_reg[lsl_pkg::CTRL_LBK_EN_BIT]
        && (LTSSM_STATE_I == lsl_pkg::LTSSM_LOOPBACK);
    wire [31:0] status_word = (32'(LTSSM_STATE_I) << lsl_pkg::ST_LTSSM_LSB)
        | (32'(cfg_lanes_reg) << lsl_pkg::ST_CFGLN_LSB)
        | (32'(width_reg) << lsl_pkg::ST_WIDTH_LSB)
        | (32'(cmpl_reg) << lsl_pkg::ST_CMPL_BIT)
        | (32'(lbk_on) << lsl_pkg::ST_LBK_ON_BIT);
    wire [31:0] rdata_next = sel_ctrl ? ctrl_reg
        : sel_status ? status_word
        : sel_fifo ? 32'(fifo_count)
        : 32'h0000_0000;

    // control write and one-cycle read data
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ctrl_reg <= lsl_pkg::CTRL_RESET;
            rdata_reg <= 32'h0000_0000;
        end else begin
            if (REG_WR_I && sel_ctrl) begin
                ctrl_reg <= 32'(REG_WDATA_I[lsl_pkg::CTRL_LBK_EN_BIT]);
            end
            rdata_reg <= REG_RD_I ? rdata_next : 32'h0000_0000;
        end
    end

    assign REG_RDATA_O = rdata_reg;

    // ------------------------------------------------------------------
    // transmit loopback through the fifo
    // ------------------------------------------------------------------
    assign TX_LBK_RDY_O = lbk_on && fifo_in_ready;
    // lane slices arrive already packed by the user; narrow core keeps lane 0
    assign tx_in_word.kcntl = TX_LBK_KCNTL_I & rx_mask.kcntl;
    assign tx_in_word.data = TX_LBK_DATA_I & rx_mask.data;

    lsl_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .CLK_I(CLK_I),
        .RST_I(RST_I),
        .in_data_i(tx_in_word),
        .in_valid_i(TX_LBK_RDY_O),
        .in_ready_o(fifo_in_ready),
        .out_data_o(fifo_out_word),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(!tx_valid_reg || LANE_TX_READY_I),
        .count_o(fifo_count)
    );

    // output stage; stalls while the lanes hold back
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            tx_out_reg <= '0;
            tx_valid_reg <= 1'b0;
        end else if (!tx_valid_reg || LANE_TX_READY_I) begin
            tx_out_reg <= fifo_out_word;
            tx_valid_reg <= fifo_out_valid;
        end
    end

    assign LANE_TX_DATA_O = tx_out_reg.data;
    assign LANE_TX_KCNTL_O = tx_out_reg.kcntl;
    assign LANE_TX_VALID_O = tx_valid_reg;

    // ------------------------------------------------------------------
    // receive loopback: per-lane slice placement
    // ------------------------------------------------------------------
    for (genvar g = 0; g < lsl_pkg::LANES; g++) begin : g_lane
        localparam bit USED = (g < LANES_USED);
        assign rx_mask.data[g*lsl_pkg::LANE_W +: lsl_pkg::LANE_W] =
            USED ? 16'hFFFF : 16'h0000;
        assign rx_mask.kcntl[g*lsl_pkg::K_W +: lsl_pkg::K_W] =
            USED ? 2'h3 : 2'h0;
    end

    // capture words only while loopback is live
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            rx_out_reg <= '0;
        end else if (lbk_on && LANE_RX_VALID_I) begin
            rx_out_reg.data <= LANE_RX_DATA_I & rx_mask.data;
            rx_out_reg.kcntl <= LANE_RX_KCNTL_I & rx_mask.kcntl;
        end else if (!lbk_on) begin
            rx_out_reg <= '0;
        end
    end

    assign RX_LBK_DATA_O = rx_out_reg.data;
    assign RX_LBK_KCNTL_O = rx_out_reg.kcntl;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_config_seen;
        in_config ##1 1'b1;
    endsequence

    sequence s_rx_taken;
        (lbk_on && LANE_RX_VALID_I) ##1 1'b1;
    endsequence

    property p_cfg_reverse;
        @(posedge CLK_I) disable iff (RST_I)
        (VARIANT == lsl_pkg::VAR_G1_X4) && in_config |=>
            CFG_LANES_O[0] == $past(LANE_IN_CFG_I[3])
            && CFG_LANES_O[3] == $past(LANE_IN_CFG_I[0]);
    endproperty
    a_cfg_reverse: assert property (p_cfg_reverse) else $error("lane order not reversed");

    property p_cfg_5g_low;
        @(posedge CLK_I) disable iff (RST_I)
        (VARIANT == lsl_pkg::VAR_G2_X2) |-> CFG_LANES_O[3:2] == 2'h0;
    endproperty
    a_cfg_5g_low: assert property (p_cfg_5g_low) else $error("5G uses upper lane bits");

    property p_width_code;
        @(posedge CLK_I) disable iff (RST_I)
        s_config_seen |-> LINK_WIDTH_O == (($past(lane_sum) == 3'h1 && !NARROW) ?
            lsl_pkg::WIDTH_X1 : ($past(lane_sum) == 3'h0 ? lsl_pkg::WIDTH_NONE : LINK_WIDTH_O))
            && $onehot0(LINK_WIDTH_O);
    endproperty
    a_width_code: assert property (p_width_code) else $error("bad width code");

    property p_width_absent;
        @(posedge CLK_I) disable iff (RST_I)
        NARROW |-> LINK_WIDTH_O == lsl_pkg::WIDTH_NONE;
    endproperty
    a_width_absent: assert property (p_width_absent) else $error("x1 drives width");

    property p_compliance;
        @(posedge CLK_I) disable iff (RST_I)
        (LTSSM_STATE_I == lsl_pkg::LTSSM_POLLING && POL_CMPL_SUB_I) |=> POL_COMPLIANCE_O;
    endproperty
    a_compliance: assert property (p_compliance) else $error("compliance flag missed");

    property p_rdy_gated;
        @(posedge CLK_I) disable iff (RST_I)
        TX_LBK_RDY_O |-> lbk_on && fifo_count != CW'(FIFO_DEPTH);
    endproperty
    a_rdy_gated: assert property (p_rdy_gated) else $error("ready while not allowed");

    property p_option_off;
        @(posedge CLK_I) disable iff (RST_I)
        !LBK_OPTION |-> !TX_LBK_RDY_O && RX_LBK_DATA_O == 64'h0 && RX_LBK_KCNTL_O == 8'h00;
    endproperty
    a_option_off: assert property (p_option_off) else $error("loopback ports live");

    property p_rx_k_pass;
        @(posedge CLK_I) disable iff (RST_I)
        s_rx_taken |-> RX_LBK_KCNTL_O == ($past(LANE_RX_KCNTL_I) & rx_mask.kcntl);
    endproperty
    a_rx_k_pass: assert property (p_rx_k_pass) else $error("rx K flags wrong");

    property p_rx_data_pass;
        @(posedge CLK_I) disable iff (RST_I)
        s_rx_taken |-> RX_LBK_DATA_O == ($past(LANE_RX_DATA_I) & rx_mask.data);
    endproperty
    a_rx_data_pass: assert property (p_rx_data_pass) else $error("rx lane data wrong");

    property p_tx_reaches_lanes;
        @(posedge CLK_I) disable iff (RST_I)
        (TX_LBK_RDY_O && fifo_count == '0 && !tx_valid_reg) |=> ##1 LANE_TX_VALID_O;
    endproperty
    a_tx_reaches_lanes: assert property (p_tx_reaches_lanes) else $error("tx word stuck");
endmodule

// [verilog/lsl_pkg.sv]
// lsl_pkg: shared constants and types for the link status and loopback block
// assumes: every user writes lsl_pkg::name, nothing is imported
package lsl_pkg;

    // ------------------------------------------------------------------
    // training state codes seen on the state input
    // ------------------------------------------------------------------
    localparam logic [3:0] LTSSM_POLLING = 4'h1;
    localparam logic [3:0] LTSSM_CONFIG = 4'h2;
    localparam logic [3:0] LTSSM_LOOPBACK = 4'h8;

    // ------------------------------------------------------------------
    // negotiated width encodings
    // ------------------------------------------------------------------
    localparam logic [2:0] WIDTH_NONE = 3'h0;
    localparam logic [2:0] WIDTH_X1 = 3'h1;
    localparam logic [2:0] WIDTH_X2 = 3'h2;
    localparam logic [2:0] WIDTH_X4 = 3'h4;

    // core flavours chosen at build time
    typedef enum logic [1:0] {
        VAR_G1_X1 = 2'b00,
        VAR_G1_X4 = 2'b01,
        VAR_G2_X2 = 2'b10
    } lsl_variant_e;

    // ------------------------------------------------------------------
    // lane geometry and fifo depth
    // ------------------------------------------------------------------
    localparam int LANES = 4;
    localparam int LANE_W = 16;
    localparam int K_W = 2;
    localparam int LBK_W_WIDE = 64;
    localparam int LBK_W_NARROW = 16;
    localparam int FIFO_DEPTH = 8;

    // ------------------------------------------------------------------
    // register map, field positions and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_FIFO = 8'h08;
    localparam int CTRL_LBK_EN_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int ST_LTSSM_LSB = 0;
    localparam int ST_CFGLN_LSB = 4;
    localparam int ST_WIDTH_LSB = 8;
    localparam int ST_CMPL_BIT = 11;
    localparam int ST_LBK_ON_BIT = 12;

    // one loopback beat: k flags beside lane data
    typedef struct packed {
        logic [7:0] kcntl;
        logic [63:0] data;
    } lsl_lbk_word_s;

endpackage

// [sim/lsl_lane_model.sv]
// lsl_lane_model: lane-side partner of the loopback path
// assumes: shares the block clock; the bench sets stalls and sends receive words
`timescale 1ns/100ps

module lsl_lane_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic stall_i,
    input wire logic [63:0] tx_data_i,
    input wire logic [7:0] tx_kcntl_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic [63:0] rx_data_o,
    output logic [7:0] rx_kcntl_o,
    output logic rx_valid_o
);
    // words taken from the block, k flags above data
    logic [71:0] got_q[$];

    // ----------------------------------------------------------------
    // idle receive lines
    // ----------------------------------------------------------------
    initial begin
        rx_data_o = 64'h0;
        rx_kcntl_o = 8'h0;
        rx_valid_o = 1'b0;
    end

    // ready follows the stall request one edge late; capture 72-bit words, k flags with data
    always @(posedge clk_i) begin
        tx_ready_o <= ~stall_i;
        if (!rst_i && tx_valid_i && tx_ready_o) begin
            got_q.push_back({tx_kcntl_i, tx_data_i});
        end
    end

    // one receive word, then lines show the inverse so stale data never looks valid
    task automatic send_rx(input logic [63:0] d, input logic [7:0] k);
        @(posedge clk_i);
        rx_valid_o <= 1'b1;
        rx_data_o <= d;
        rx_kcntl_o <= k;
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_data_o <= ~d;
        rx_kcntl_o <= ~k;
    endtask
endmodule

// [sim/lsl_top_tb_top.sv]
// lsl_top_tb_top: self-checking bench for status outputs and loopback paths
// assumes: lsl_top in its default four-lane form with loopback present, plus a
// second build as the 5G two-lane core with the loopback option left out
`timescale 1ns/100ps

module lsl_top_tb_top;
    logic CLK_I = 1'b0;
    logic RST_I = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [3:0] state = 4'h0;
    logic cmpl_sub = 1'b0;
    logic [3:0] lanes = 4'h0;
    logic [3:0] cfg_lanes;
    logic [2:0] link_width;
    logic compliance;
    logic tx_rdy;
    logic [7:0] tx_k = 8'h0;
    logic [63:0] tx_d = 64'h0;
    logic [7:0] rx_k;
    logic [63:0] rx_d;
    logic [63:0] ln_tx_d;
    logic [7:0] ln_tx_k;
    logic ln_tx_v;
    logic ln_tx_rdy;
    logic [63:0] ln_rx_d;
    logic [7:0] ln_rx_k;
    logic ln_rx_v;
    logic stall = 1'b0;
    int n_errors = 0;
    int samples_checked = 0;
    logic [3:0] cfg_lanes_g2;
    logic [2:0] link_width_g2;
    logic tx_rdy_g2;
    logic [7:0] rx_k_g2;
    logic [63:0] rx_d_g2;

    lsl_top uut (.CLK_I(CLK_I), .RST_I(RST_I), .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata),
        .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata), .LTSSM_STATE_I(state),
        .POL_CMPL_SUB_I(cmpl_sub), .LANE_IN_CFG_I(lanes), .CFG_LANES_O(cfg_lanes),
        .LINK_WIDTH_O(link_width), .POL_COMPLIANCE_O(compliance), .TX_LBK_RDY_O(tx_rdy),
        .TX_LBK_KCNTL_I(tx_k), .TX_LBK_DATA_I(tx_d), .RX_LBK_KCNTL_O(rx_k),
        .RX_LBK_DATA_O(rx_d), .LANE_TX_DATA_O(ln_tx_d), .LANE_TX_KCNTL_O(ln_tx_k),
        .LANE_TX_VALID_O(ln_tx_v), .LANE_TX_READY_I(ln_tx_rdy), .LANE_RX_DATA_I(ln_rx_d),
        .LANE_RX_KCNTL_I(ln_rx_k), .LANE_RX_VALID_I(ln_rx_v));

    lsl_lane_model lm (.clk_i(CLK_I), .rst_i(RST_I), .stall_i(stall), .tx_data_i(ln_tx_d),
        .tx_kcntl_i(ln_tx_k), .tx_valid_i(ln_tx_v), .tx_ready_o(ln_tx_rdy),
        .rx_data_o(ln_rx_d), .rx_kcntl_o(ln_rx_k), .rx_valid_o(ln_rx_v));

    // second build: 5G two-lane core, loopback option absent, same inputs
    lsl_top #(.VARIANT(lsl_pkg::VAR_G2_X2), .LBK_OPTION(1'b0)) uut_g2 (.CLK_I(CLK_I),
        .RST_I(RST_I), .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr),
        .REG_RD_I(reg_rd), .REG_RDATA_O(), .LTSSM_STATE_I(state), .POL_CMPL_SUB_I(cmpl_sub),
        .LANE_IN_CFG_I(lanes), .CFG_LANES_O(cfg_lanes_g2), .LINK_WIDTH_O(link_width_g2),
        .POL_COMPLIANCE_O(), .TX_LBK_RDY_O(tx_rdy_g2), .TX_LBK_KCNTL_I(tx_k),
        .TX_LBK_DATA_I(tx_d), .RX_LBK_KCNTL_O(rx_k_g2), .RX_LBK_DATA_O(rx_d_g2),
        .LANE_TX_DATA_O(), .LANE_TX_KCNTL_O(), .LANE_TX_VALID_O(),
        .LANE_TX_READY_I(ln_tx_rdy), .LANE_RX_DATA_I(ln_rx_d), .LANE_RX_KCNTL_I(ln_rx_k),
        .LANE_RX_VALID_I(ln_rx_v));

    // ----------------------------------------------------------------
    // clock and shared tasks
    // ----------------------------------------------------------------
    initial begin
        forever #5 CLK_I = ~CLK_I;
    end

    // value compare, four-state exact
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("errors=%0d checks=%0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_I);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge CLK_I);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge CLK_I);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge CLK_I);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // lane n carries 16'hNN00+idx, distinct per lane and per word
    function automatic lsl_pkg::lsl_lbk_word_s mk(input int i);
        lsl_pkg::lsl_lbk_word_s w;
        w.data = {16'h3300 + 16'(i), 16'h2200 + 16'(i), 16'h1100 + 16'(i), 16'(i)};
        w.kcntl = 8'(i) ^ 8'hA5;
        return w;
    endfunction

    task automatic wait_cycles(input int c);
        repeat (c) @(posedge CLK_I);
        #1;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_regs();
        logic [31:0] v;
        chk({cfg_lanes, link_width, compliance, tx_rdy}, 9'h0);
        chk(rx_d, 64'h0);
        reg_read(lsl_pkg::REG_CTRL, v);
        chk(v, lsl_pkg::CTRL_RESET);
        reg_read(8'h0C, v);
        chk(v, 32'h0);
        reg_write(lsl_pkg::REG_CTRL, 32'h0000_0001);
        reg_read(lsl_pkg::REG_CTRL, v);
        chk(v, 32'h0000_0001);
    endtask

    task automatic t_cfg_lanes();
        logic [3:0] tbl[5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hF};
        logic [2:0] wtbl[5] = '{lsl_pkg::WIDTH_NONE, lsl_pkg::WIDTH_X1, lsl_pkg::WIDTH_X2,
            lsl_pkg::WIDTH_X2, lsl_pkg::WIDTH_X4};
        logic [2:0] wg2[5] = '{lsl_pkg::WIDTH_NONE, lsl_pkg::WIDTH_X1, lsl_pkg::WIDTH_X2,
            lsl_pkg::WIDTH_X2, lsl_pkg::WIDTH_X2};
        logic [3:0] e;
        for (int i = 0; i < 5; i++) begin
            @(posedge CLK_I);
            state <= lsl_pkg::LTSSM_CONFIG;
            lanes <= tbl[i];
            wait_cycles(2);
            for (int b = 0; b < 4; b++) e[3-b] = tbl[i][b];
            chk(cfg_lanes, e);
            chk(link_width, wtbl[i]);
            chk(cfg_lanes_g2, {2'b00, tbl[i][0], tbl[i][1]});
            chk(link_width_g2, wg2[i]);
        end
        @(posedge CLK_I);
        state <= lsl_pkg::LTSSM_POLLING;
        lanes <= 4'h5;
        wait_cycles(2);
        chk({cfg_lanes, link_width}, {4'hF, lsl_pkg::WIDTH_X4});
        chk({cfg_lanes_g2, link_width_g2}, {4'h3, lsl_pkg::WIDTH_X2});
    endtask

    task automatic t_compliance();
        logic [4:0] st[3] = '{{lsl_pkg::LTSSM_POLLING, 1'b1}, {lsl_pkg::LTSSM_POLLING, 1'b0},
            {lsl_pkg::LTSSM_CONFIG, 1'b1}};
        logic [31:0] v;
        for (int i = 0; i < 3; i++) begin
            @(posedge CLK_I);
            {state, cmpl_sub} <= st[i];
            wait_cycles(2);
            chk(compliance, i == 0);
            if (i == 0) begin
                reg_read(lsl_pkg::REG_STATUS, v);
                chk(v, 32'(lsl_pkg::LTSSM_POLLING) | (32'hF << lsl_pkg::ST_CFGLN_LSB)
                    | (32'(lsl_pkg::WIDTH_X4) << lsl_pkg::ST_WIDTH_LSB)
                    | (32'h1 << lsl_pkg::ST_CMPL_BIT));
            end
        end
        @(posedge CLK_I);
        cmpl_sub <= 1'b0;
    endtask

    task automatic t_tx_fill_drain();
        logic r;
        int n = 0;
        int t = 0;
        logic [31:0] v;
        @(posedge CLK_I);
        {tx_k, tx_d} <= mk(0);
        stall <= 1'b1;
        @(posedge CLK_I);
        state <= lsl_pkg::LTSSM_LOOPBACK;
        for (int i = 0; i < 26; i++) begin
            @(negedge CLK_I);
            r = tx_rdy;
            if (i == 20) begin
                chk(n, lsl_pkg::FIFO_DEPTH + 1);
                chk(lm.got_q.size(), 0);
                reg_read(lsl_pkg::REG_FIFO, v);
                chk(v, 32'(lsl_pkg::FIFO_DEPTH));
            end
            @(posedge CLK_I);
            if (r) begin
                n++;
                {tx_k, tx_d} <= mk(n);
            end
            if (i == 20) stall <= 1'b0;
            if (i == 25) state <= lsl_pkg::LTSSM_CONFIG;
        end
        while (lm.got_q.size() != n && t < 60) begin
            @(posedge CLK_I);
            t++;
        end
        chk(lm.got_q.size(), n);
        for (int j = 0; j < lm.got_q.size(); j++) chk(lm.got_q[j], mk(j));
        chk(tx_rdy, 1'b0);
    endtask

    task automatic t_rx_words();
        @(posedge CLK_I);
        state <= lsl_pkg::LTSSM_LOOPBACK;
        lm.send_rx(64'hD3C3_B2A2_9181_7060, 8'hC1);
        #1;
        chk({rx_k, rx_d}, {8'hC1, 64'hD3C3_B2A2_9181_7060});
        chk({rx_k_g2, rx_d_g2}, 72'h0);
        chk(tx_rdy_g2, 1'b0);
        wait_cycles(2);
        chk({rx_k, rx_d}, {8'hC1, 64'hD3C3_B2A2_9181_7060});
        lm.send_rx(64'h0F1E_2D3C_4B5A_6978, 8'h3C);
        #1;
        chk({rx_k, rx_d}, {8'h3C, 64'h0F1E_2D3C_4B5A_6978});
        @(posedge CLK_I);
        state <= lsl_pkg::LTSSM_CONFIG;
        wait_cycles(2);
        chk({rx_k, rx_d}, 72'h0);
        chk(tx_rdy, 1'b0);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge CLK_I);
        RST_I <= 1'b0;
        #1;
        t_reset_regs();
        t_cfg_lanes();
        t_compliance();
        t_tx_fill_drain();
        t_rx_words();
        report_and_stop();
    end
endmodule
